/* uart_baud_gen_frame_format.sv */
// Baud generator, frame transmitter and receiver with their CPU registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_cfg.svh"
module uart_baud_gen_frame_format
    import uart_baud_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire bus_req_s i_bus,
    input wire logic i_rxd,
    output logic [7:0] o_rdata,
    output logic o_txd,
    output logic o_tx_serial,
    output logic o_rx_serial,
    output logic o_tx_done,
    output logic o_rx_done,
    output logic o_rx_err
);
    function automatic logic [7:0] presc_mask(input logic [2:0] ps);
        presc_mask = 8'((9'h002 << ps) - 9'h001);
    endfunction : presc_mask

    logic [7:0] serial_mode_register_q, serial_mode_register_d;
    logic [7:0] baud_divider_control_q, baud_divider_control_d;
    logic [7:0] receive_status_register_q, receive_status_register_d;
    logic [7:0] rxbuf_q, rxbuf_d, rdata_q, rdata_d;
    logic rx_full_q, rx_full_d;
    logic rx_done_now, rx_pe_now, rx_fe_now;
    logic [7:0] rx_data_fin;

    logic txe, rxe, cl, sl, restart, sck_tick;
    logic [1:0] pm;
    logic [4:0] div_last;
    assign txe = serial_mode_register_q[`TRANSMIT_ENABLE_BIT];
    assign rxe = serial_mode_register_q[`RECEIVE_ENABLE_BIT];
    assign pm = serial_mode_register_q[`PARITY_SELECT_HI:`PARITY_SELECT_LO];
    assign cl = serial_mode_register_q[`CHAR_LENGTH_SELECT];
    assign sl = serial_mode_register_q[`STOP_LENGTH_SELECT];
    assign div_last = `DIVISOR_BASE
        + {1'b0, baud_divider_control_q[`DIVISOR_HI:`DIVISOR_LO]} - 5'h01;

    logic rd_rxb, baud_wr;
    assign rd_rxb = i_bus.rd && (i_bus.addr == `ADDR_RX_BUFFER);
    assign baud_wr = i_bus.wr && (i_bus.addr == `ADDR_BAUD_DIVIDER);

    always_comb begin
        serial_mode_register_d = serial_mode_register_q;
        baud_divider_control_d = baud_divider_control_q;
        receive_status_register_d = receive_status_register_q;
        rxbuf_d = rxbuf_q;
        rx_full_d = rx_full_q;
        rdata_d = rdata_q;
        if (i_bus.wr && (i_bus.addr == `ADDR_SERIAL_MODE)) begin
            serial_mode_register_d = i_bus.wdata & `MODE_WRITE_MASK;
        end
        // whole-byte write, bit 7 held at zero
        if (baud_wr) begin
            baud_divider_control_d = i_bus.wdata & `BAUD_WRITE_MASK;
        end
        if (rd_rxb) begin
            receive_status_register_d = `RESET_VALUE_8;
            rx_full_d = 1'b0;
        end
        // error flags; a completing frame wins over a buffer read
        if (rx_done_now) begin
            rxbuf_d = rx_data_fin;
            receive_status_register_d = `RESET_VALUE_8;
            receive_status_register_d[`STATUS_PARITY_ERR] = rx_pe_now;
            receive_status_register_d[`STATUS_FRAMING_ERR] = rx_fe_now;
            receive_status_register_d[`STATUS_OVERRUN_ERR] = rx_full_q;
            rx_full_d = 1'b1;
        end
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                `ADDR_SERIAL_MODE: rdata_d = serial_mode_register_q;
                `ADDR_RECEIVE_STATUS: rdata_d = receive_status_register_q;
                `ADDR_BAUD_DIVIDER: rdata_d = baud_divider_control_q;
                `ADDR_RX_BUFFER: rdata_d = rxbuf_q;
                default: rdata_d = `RESET_VALUE_8;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            serial_mode_register_q <= `RESET_VALUE_8;
            baud_divider_control_q <= `RESET_VALUE_8;
            receive_status_register_q <= `RESET_VALUE_8;
            rxbuf_q <= `RESET_VALUE_8;
            rdata_q <= `RESET_VALUE_8;
            rx_full_q <= 1'b0;
        end else begin
            serial_mode_register_q <= serial_mode_register_d;
            baud_divider_control_q <= baud_divider_control_d;
            receive_status_register_q <= receive_status_register_d;
            rxbuf_q <= rxbuf_d;
            rdata_q <= rdata_d;
            rx_full_q <= rx_full_d;
        end
    end

    // Baud chain and transmitter.
    logic [7:0] pre_q, pre_d, tx_sh_q, tx_sh_d;
    logic en_any_q, en_any_d, tx_ph_q, tx_ph_d, tx_par_q, tx_par_d, tx_stop2_q, tx_stop2_d;
    logic txd_q, txd_d, tx_done_q, tx_done_d, tx_ser_q, tx_ser_d;
    logic [4:0] tx_cnt_q, tx_cnt_d;
    logic [2:0] tx_bit_q, tx_bit_d;
    tx_state_e tx_st_q, tx_st_d;
    logic tx_wrap, tx_bit_end, tx_load;

    assign restart = (txe || rxe) && !en_any_q;
    // counter clock is system clock over 2 to the p+1
    assign sck_tick = (pre_q == presc_mask(baud_divider_control_q[`PRESCALE_HI:`PRESCALE_LO]));
    assign tx_wrap = sck_tick && (tx_cnt_q == div_last);
    assign tx_bit_end = tx_wrap && tx_ph_q;
    assign tx_load = i_bus.wr && (i_bus.addr == `ADDR_TX_SHIFT) && txe && (tx_st_q == TX_IDLE);

    always_comb begin
        en_any_d = txe || rxe;
        pre_d = (restart || sck_tick) ? 8'h00 : 8'(pre_q + 8'h01);
        tx_st_d = tx_st_q;
        tx_sh_d = tx_sh_q;
        tx_par_d = tx_par_q;
        tx_stop2_d = tx_stop2_q;
        tx_bit_d = tx_bit_q;
        tx_cnt_d = tx_cnt_q;
        tx_ph_d = tx_ph_q;
        tx_done_d = 1'b0;
        tx_ser_d = txe;
        // two counter wraps make one bit period
        if (tx_st_q != TX_IDLE && sck_tick) begin
            tx_cnt_d = tx_wrap ? 5'h00 : 5'(tx_cnt_q + 5'h01);
            tx_ph_d = tx_ph_q ^ tx_wrap;
        end
        unique case (tx_st_q)
            TX_IDLE: begin
                if (tx_load) begin
                    // drop bit 7 for 7-bit characters
                    tx_sh_d = cl ? i_bus.wdata : {1'b0, i_bus.wdata[6:0]};
                    unique case (pm)
                        `PARITY_ODD: tx_par_d = ~^tx_sh_d;
                        `PARITY_EVEN: tx_par_d = ^tx_sh_d;
                        default: tx_par_d = 1'b0;
                    endcase
                    tx_stop2_d = sl;
                    tx_bit_d = 3'h0;
                    tx_cnt_d = 5'h00;
                    tx_ph_d = 1'b0;
                    tx_st_d = TX_START;
                end
            end
            TX_START: if (tx_bit_end) tx_st_d = TX_DATA;
            TX_DATA: begin
                if (tx_bit_end) begin
                    tx_sh_d = {1'b0, tx_sh_q[7:1]};
                    tx_bit_d = 3'(tx_bit_q + 3'h1);
                    if (tx_bit_q == (cl ? `LAST_BIT_8 : `LAST_BIT_7)) begin
                        tx_st_d = (pm == `PARITY_NONE) ? TX_STOP : TX_PAR;
                    end
                end
            end
            TX_PAR: if (tx_bit_end) tx_st_d = TX_STOP;
            TX_STOP: begin
                if (tx_bit_end) begin
                    tx_stop2_d = 1'b0;
                    if (!tx_stop2_q) begin
                        tx_st_d = TX_IDLE;
                        tx_done_d = 1'b1;
                    end
                end
            end
        endcase
        // clearing the enable hands the pin back at once
        if (!txe) tx_st_d = TX_IDLE;
        // low start bit then LSB first
        unique case (tx_st_d)
            TX_START: txd_d = 1'b0;
            TX_DATA: txd_d = tx_sh_d[0];
            TX_PAR: txd_d = tx_par_d;
            default: txd_d = 1'b1;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            en_any_q <= 1'b0;
            pre_q <= 8'h00;
            tx_st_q <= TX_IDLE;
            tx_sh_q <= 8'h00;
            tx_par_q <= 1'b0;
            tx_stop2_q <= 1'b0;
            tx_bit_q <= 3'h0;
            tx_cnt_q <= 5'h00;
            tx_ph_q <= 1'b0;
            txd_q <= 1'b1;
            tx_done_q <= 1'b0;
            tx_ser_q <= 1'b0;
        end else begin
            en_any_q <= en_any_d;
            pre_q <= pre_d;
            tx_st_q <= tx_st_d;
            tx_sh_q <= tx_sh_d;
            tx_par_q <= tx_par_d;
            tx_stop2_q <= tx_stop2_d;
            tx_bit_q <= tx_bit_d;
            tx_cnt_q <= tx_cnt_d;
            tx_ph_q <= tx_ph_d;
            txd_q <= txd_d;
            tx_done_q <= tx_done_d;
            tx_ser_q <= tx_ser_d;
        end
    end

    // Receiver. The pin passes three flops and a change counts once the last two agree.
    logic s1_q, s2_q, s3_q, rxd_q, rxd_d, rx_ph_q, rx_ph_d, rx_acc_q, rx_acc_d;
    logic rx_done_q, rx_err_q, rx_ser_q;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic [4:0] rx_cnt_q, rx_cnt_d;
    logic [2:0] rx_bit_q, rx_bit_d;
    rx_state_e rx_st_q, rx_st_d;
    logic rx_wrap, rx_mid;
    assign rx_wrap = sck_tick && (rx_cnt_q == div_last);
    assign rx_mid = rx_wrap && rx_ph_q;
    // bit 7 zero for 7-bit characters
    assign rx_data_fin = cl ? rx_sh_q : {1'b0, rx_sh_q[7:1]};

    always_comb begin
        rxd_d = (s2_q == s3_q) ? s3_q : rxd_q;
        rx_st_d = rx_st_q;
        rx_sh_d = rx_sh_q;
        rx_bit_d = rx_bit_q;
        rx_acc_d = rx_acc_q;
        rx_cnt_d = rx_cnt_q;
        rx_ph_d = rx_ph_q;
        rx_done_now = 1'b0;
        rx_pe_now = 1'b0;
        rx_fe_now = 1'b0;
        if (rx_st_q != RX_IDLE && sck_tick) begin
            rx_cnt_d = rx_wrap ? 5'h00 : 5'(rx_cnt_q + 5'h01);
            rx_ph_d = rx_ph_q ^ rx_wrap;
        end
        unique case (rx_st_q)
            RX_IDLE: begin
                if (rxd_q && !rxd_d) begin
                    rx_cnt_d = 5'h00;
                    rx_ph_d = 1'b0;
                    rx_st_d = RX_START;
                end
            end
            RX_START: begin
                // half a bit after the edge, then whole bits
                if (rx_wrap) begin
                    rx_ph_d = 1'b0;
                    rx_bit_d = 3'h0;
                    rx_acc_d = 1'b0;
                    rx_st_d = rxd_q ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_mid) begin
                    rx_sh_d = {rxd_q, rx_sh_q[7:1]};
                    rx_acc_d = rx_acc_q ^ rxd_q;
                    rx_bit_d = 3'(rx_bit_q + 3'h1);
                    if (rx_bit_q == (cl ? `LAST_BIT_8 : `LAST_BIT_7)) begin
                        rx_st_d = (pm == `PARITY_NONE) ? RX_STOP : RX_PAR;
                    end
                end
            end
            RX_PAR: begin
                if (rx_mid) begin
                    rx_acc_d = rx_acc_q ^ rxd_q;
                    rx_st_d = RX_STOP;
                end
            end
            RX_STOP: begin
                // only the first stop bit is checked
                if (rx_mid && rxe) begin
                    rx_done_now = 1'b1;
                    rx_fe_now = !rxd_q;
                    rx_pe_now = (pm == `PARITY_ODD && !rx_acc_q) || (pm == `PARITY_EVEN && rx_acc_q);
                    rx_st_d = RX_IDLE;
                end
            end
        endcase
        // clearing the enable aborts with no status change
        if (!rxe) rx_st_d = RX_IDLE;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            rxd_q <= 1'b1;
            rx_st_q <= RX_IDLE;
            rx_sh_q <= 8'h00;
            rx_bit_q <= 3'h0;
            rx_acc_q <= 1'b0;
            rx_cnt_q <= 5'h00;
            rx_ph_q <= 1'b0;
            rx_done_q <= 1'b0;
            rx_err_q <= 1'b0;
            rx_ser_q <= 1'b0;
        end else begin
            s1_q <= i_rxd;
            s2_q <= s1_q;
            s3_q <= s2_q;
            rxd_q <= rxd_d;
            rx_st_q <= rx_st_d;
            rx_sh_q <= rx_sh_d;
            rx_bit_q <= rx_bit_d;
            rx_acc_q <= rx_acc_d;
            rx_cnt_q <= rx_cnt_d;
            rx_ph_q <= rx_ph_d;
            rx_done_q <= rx_done_now;
            rx_err_q <= rx_done_now && (rx_pe_now || rx_fe_now || rx_full_q);
            rx_ser_q <= rxe;
        end
    end

    assign o_rdata = rdata_q;
    assign o_txd = txd_q;
    assign o_tx_serial = tx_ser_q;
    assign o_rx_serial = rx_ser_q;
    assign o_tx_done = tx_done_q;
    assign o_rx_done = rx_done_q;
    assign o_rx_err = rx_err_q;

    // Cycles since the last transmit bit boundary, read only by the checks.
    logic [15:0] tx_cyc_q, tx_period;
    assign tx_period = 16'(({11'h000, div_last} + 16'h0001)
        << ({1'b0, baud_divider_control_q[`PRESCALE_HI:`PRESCALE_LO]} + 4'h2));
    always_ff @(posedge i_sys_clk) begin
        tx_cyc_q <= (i_reset || tx_load || tx_bit_end) ? 16'h0000 : 16'(tx_cyc_q + 16'h0001);
    end

    sequence stop_low_seen;
        rx_st_q == RX_STOP && rx_mid && rxe && !rxd_q;
    endsequence
    sequence tx_steady_bit;
        tx_bit_end && tx_st_q != TX_START && tx_st_q != TX_IDLE;
    endsequence

    reset_clears_baud_a: assert property (@(posedge i_sys_clk) i_reset |=> baud_divider_control_q == 8'h00) else $error("baud divider not cleared");
    baud_top_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) !baud_divider_control_q[7]) else $error("baud divider bit 7 set");
    // A prescale change or a restart between the two ticks legitimately moves the second one.
    prescale_one_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (sck_tick && baud_divider_control_q[`PRESCALE_HI:`PRESCALE_LO] == 3'h0 && !baud_wr)
        ##1 (!restart && !baud_wr) |-> !sck_tick ##1 sck_tick)
        else $error("prescale by two wrong");
    bit_period_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) tx_steady_bit |-> tx_cyc_q == 16'(tx_period - 16'h0001)) else $error("transmit bit period wrong");
    start_low_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) tx_load |=> tx_st_q == TX_START && !o_txd) else $error("start bit not low");
    stop_high_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) tx_st_q == TX_STOP || tx_st_q == TX_IDLE |-> o_txd) else $error("stop or idle not high");
    seven_bit_tx_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) tx_load && !cl |=> !tx_sh_q[7]) else $error("bit 7 kept in 7-bit mode");
    seven_bit_rx_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) o_rx_done && !cl |-> !rxbuf_q[7]) else $error("received bit 7 not zero");
    framing_flag_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) stop_low_seen |=> receive_status_register_q[`STATUS_FRAMING_ERR] && o_rx_err) else $error("framing error not flagged");
    enable_restart_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) restart |=> pre_q == 8'h00) else $error("divide chain not restarted");
    pin_release_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) !txe |=> !o_tx_serial && o_txd) else $error("transmit pin not released");
endmodule : uart_baud_gen_frame_format
`default_nettype wire

/* uart_baud_cfg.svh */
// Register addresses, field positions, reset values and counts of the serial transceiver.
`ifndef UART_BAUD_CFG_SVH
`define UART_BAUD_CFG_SVH
`define ADDR_SERIAL_MODE 16'hFFA0
`define ADDR_RECEIVE_STATUS 16'hFFA1
`define ADDR_BAUD_DIVIDER 16'hFFA2
`define ADDR_TX_SHIFT 16'hFFA3
`define ADDR_RX_BUFFER 16'hFFA4
`define RESET_VALUE_8 8'h00
`define TRANSMIT_ENABLE_BIT 7
`define RECEIVE_ENABLE_BIT 6
`define PARITY_SELECT_HI 5
`define PARITY_SELECT_LO 4
`define CHAR_LENGTH_SELECT 3
`define STOP_LENGTH_SELECT 2
`define MODE_WRITE_MASK 8'hFE
`define BAUD_WRITE_MASK 8'h7F
`define PRESCALE_HI 6
`define PRESCALE_LO 4
`define DIVISOR_HI 3
`define DIVISOR_LO 0
`define DIVISOR_BASE 5'h10
`define STATUS_PARITY_ERR 2
`define STATUS_FRAMING_ERR 1
`define STATUS_OVERRUN_ERR 0
`define PARITY_NONE 2'h0
`define PARITY_ZERO 2'h1
`define PARITY_ODD 2'h2
`define PARITY_EVEN 2'h3
`define LAST_BIT_7 3'h6
`define LAST_BIT_8 3'h7
`endif

/* uart_baud_pkg.sv */
// Types shared by the serial transceiver.
`default_nettype none
package uart_baud_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } bus_req_s;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;
endpackage : uart_baud_pkg
`default_nettype wire

/* remote_serial_peer.sv */
// Model of the remote serial transceiver that faces the block's line pins.
`timescale 1ns/1ps
`default_nettype none
module remote_serial_peer (
    input wire logic i_clk,
    input wire logic i_line_in,
    output logic o_line_out
);
    // Set by the bench from the baud setting, so both ends share one bit time.
    int bit_cyc = 68;
    initial o_line_out = 1'b1;

    task automatic send(input logic [7:0] data, input int nbits, input bit has_par,
                        input logic par, input logic stop);
        @(posedge i_clk) o_line_out <= 1'b0;
        repeat (bit_cyc) @(posedge i_clk);
        for (int i = 0; i < nbits; i++) begin
            o_line_out <= data[i];
            repeat (bit_cyc) @(posedge i_clk);
        end
        if (has_par) begin
            o_line_out <= par;
            repeat (bit_cyc) @(posedge i_clk);
        end
        o_line_out <= stop;
        repeat (bit_cyc) @(posedge i_clk);
        // The line idles high between frames, like a pulled-up wire.
        o_line_out <= 1'b1;
        repeat (bit_cyc) @(posedge i_clk);
    endtask : send

    task automatic recv(input int nbits, input bit has_par, output logic [7:0] data,
                        output logic [3:0] tail);
        int guard;
        data = 8'h00;
        tail = 4'h0;
        guard = 0;
        while (i_line_in !== 1'b0 && guard < 400) begin
            @(posedge i_clk);
            guard++;
        end
        repeat (bit_cyc / 2) @(posedge i_clk);
        tail[3] = i_line_in;
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_cyc) @(posedge i_clk);
            data[i] = i_line_in;
        end
        if (has_par) begin
            repeat (bit_cyc) @(posedge i_clk);
            tail[2] = i_line_in;
        end
        repeat (bit_cyc) @(posedge i_clk);
        tail[1] = i_line_in;
        repeat (bit_cyc) @(posedge i_clk);
        tail[0] = i_line_in;
    endtask : recv
endmodule : remote_serial_peer
`default_nettype wire

/* uart_baud_gen_frame_format_bench.sv */
// Self-checking bench for the baud generator and serial frame block.
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_cfg.svh"
module uart_baud_gen_frame_format_bench;
    import uart_baud_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    bus_req_s bus = '0;
    logic rxd;
    logic [7:0] rdata;
    logic txd, tx_serial, rx_serial, tx_done, rx_done, rx_err;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;

    uart_baud_gen_frame_format dut (.i_sys_clk(clk), .i_reset(rst), .i_bus(bus),
        .i_rxd(rxd), .o_rdata(rdata), .o_txd(txd), .o_tx_serial(tx_serial),
        .o_rx_serial(rx_serial), .o_tx_done(tx_done), .o_rx_done(rx_done),
        .o_rx_err(rx_err));
    remote_serial_peer peer (.i_clk(clk), .i_line_in(txd), .o_line_out(rxd));

    always #50 clk = ~clk;

    // Eleven frames of 68-cycle bits fit well inside this ceiling.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge clk) bus <= '{addr, 1'b1, 1'b0, data};
        @(posedge clk) bus <= '0;
    endtask : wr

    task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp, input string what);
        @(posedge clk) bus <= '{addr, 1'b0, 1'b1, 8'h00};
        @(posedge clk) bus <= '0;
        #1;
        check(rdata, exp, what);
    endtask : rd_chk

    task automatic wait_done(input bit rx_side, output bit seen, output logic err);
        seen = 1'b0;
        err = 1'b0;
        for (int i = 0; i < 2000 && !seen; i++) begin
            @(posedge clk);
            #1;
            seen = rx_side ? (rx_done === 1'b1) : (tx_done === 1'b1);
            err = rx_err;
        end
    endtask : wait_done

    task automatic set_mode(input logic [7:0] mode);
        wr(`ADDR_SERIAL_MODE, 8'h00);
        wr(`ADDR_SERIAL_MODE, mode);
        // The pin-use flags are registered copies of the enables, one edge behind.
        @(posedge clk);
        #1;
        check({6'h00, tx_serial, rx_serial}, {6'h00, mode[7:6]}, "pin use");
    endtask : set_mode

    task automatic do_tx(input logic [7:0] data, input int nbits, input bit has_par,
                         input logic [7:0] exp_data, input logic [3:0] exp_tail);
        logic [7:0] got;
        logic [3:0] tail;
        bit seen;
        logic err;
        fork
            peer.recv(nbits, has_par, got, tail);
            begin
                wr(`ADDR_TX_SHIFT, data);
                wait_done(1'b0, seen, err);
            end
        join
        check(got, exp_data, "tx data");
        check({4'h0, tail}, {4'h0, exp_tail}, "tx start parity stop");
        check({7'h00, seen}, 8'h01, "tx done");
    endtask : do_tx

    task automatic do_rx(input logic [7:0] data, input int nbits, input bit has_par,
                         input logic par, input logic stop, input bit rd,
                         input logic [7:0] exp_st, input logic [7:0] exp_buf);
        bit seen;
        logic err;
        fork
            peer.send(data, nbits, has_par, par, stop);
            wait_done(1'b1, seen, err);
        join
        check({7'h00, seen}, 8'h01, "rx done");
        check({7'h00, err}, {7'h00, exp_st != 8'h00}, "rx error pulse");
        if (rd) begin
            rd_chk(`ADDR_RECEIVE_STATUS, exp_st, "rx status");
            rd_chk(`ADDR_RX_BUFFER, exp_buf, "rx buffer");
        end
    endtask : do_rx

    task automatic test_regs();
        rd_chk(`ADDR_BAUD_DIVIDER, 8'h00, "baud reset");
        wr(`ADDR_BAUD_DIVIDER, 8'hFF);
        rd_chk(`ADDR_BAUD_DIVIDER, 8'h7F, "baud bit 7");
        rd_chk(16'h0000, 8'h00, "unmapped read");
        // Prescale 0 and divisor 1 give 4 * 17 = 68 cycles a bit.
        wr(`ADDR_BAUD_DIVIDER, 8'h01);
        rd_chk(`ADDR_BAUD_DIVIDER, 8'h01, "baud value");
        peer.bit_cyc = 4 * 17;
        $display("test_regs finished");
    endtask : test_regs

    task automatic test_tx_even8();
        set_mode(8'hBC);
        do_tx(8'hA7, 8, 1'b1, 8'hA7, 4'b0111);
        $display("test_tx_even8 finished");
    endtask : test_tx_even8

    task automatic test_tx_zero7();
        set_mode(8'h90);
        do_tx(8'hD5, 7, 1'b1, 8'h55, 4'b0011);
        $display("test_tx_zero7 finished");
    endtask : test_tx_zero7

    task automatic test_tx_odd_none();
        set_mode(8'hA8);
        do_tx(8'h3C, 8, 1'b1, 8'h3C, 4'b0111);
        set_mode(8'h88);
        do_tx(8'h81, 8, 1'b0, 8'h81, 4'b0011);
        $display("test_tx_odd_none finished");
    endtask : test_tx_odd_none

    task automatic test_rx_even_zero();
        set_mode(8'h70);
        do_rx(8'h2B, 7, 1'b1, 1'b1, 1'b1, 1'b1, 8'h04, 8'h2B);
        set_mode(8'h50);
        do_rx(8'h2B, 7, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 8'h2B);
        $display("test_rx_even_zero finished");
    endtask : test_rx_even_zero

    task automatic test_rx_odd7();
        set_mode(8'h60);
        do_rx(8'h2B, 7, 1'b1, 1'b0, 1'b1, 1'b1, 8'h04, 8'h2B);
        do_rx(8'h2B, 7, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 8'h2B);
        $display("test_rx_odd7 finished");
    endtask : test_rx_odd7

    task automatic test_rx_errors();
        set_mode(8'h4C);
        do_rx(8'hC3, 8, 1'b0, 1'b0, 1'b0, 1'b1, 8'h02, 8'hC3);
        do_rx(8'h5A, 8, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
        do_rx(8'hA5, 8, 1'b0, 1'b0, 1'b1, 1'b1, 8'h01, 8'hA5);
        $display("test_rx_errors finished");
    endtask : test_rx_errors

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check({7'h00, txd}, 8'h01, "idle line");
        test_regs();
        test_tx_even8();
        test_tx_zero7();
        test_tx_odd_none();
        test_rx_odd7();
        test_rx_even_zero();
        test_rx_errors();
        final_report();
    end
endmodule : uart_baud_gen_frame_format_bench
`default_nettype wire
